// ---- hdl/cdsp_pkg.sv ----
// Purpose: Shared constants and types of the serial register-access port.
// Assumes: 10-bit register pointer and 16-bit register words.
// Notes: Used by cdsp_port and the bench through scoped names only.
package cdsp_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam logic [9:0] PTR_MAX = 10'h3FF;
  localparam logic [9:0] PTR_ZERO = 10'h000;
  // Command word layout.
  localparam logic [4:0] SPI_EN_PAT = 5'h1C;
  localparam int CMD_EN_HI = 15;
  localparam int CMD_EN_LO = 11;
  localparam int CMD_DIR_BIT = 10;
  localparam logic [3:0] SPI_LAST_BIT = 4'hF;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  // Two-wire address is the fixed prefix followed by the two select pins.
  localparam logic [4:0] I2C_ADDR_BASE = 5'h0B;
  localparam logic [3:0] I2C_LAST_DATA = 4'h7;
  localparam logic [3:0] I2C_ACK_SLOT = 4'h8;
  localparam logic [1:0] IDX_PTR_HI = 2'h0;
  localparam logic [1:0] IDX_PTR_LO = 2'h1;
  localparam logic [1:0] IDX_DAT_HI = 2'h2;
  localparam logic [1:0] IDX_DAT_LO = 2'h3;
  typedef enum logic [1:0] {SP_CMD, SP_WR, SP_RD, SP_SKIP} cdsp_spi_e;
  typedef enum logic [1:0] {I2_IDLE, I2_DEV, I2_WR, I2_RD} cdsp_i2c_e;
endpackage

// ---- hdl/cdsp_sync.sv ----
// Purpose: Two-flop synchroniser for pin levels.
// Assumes: Inputs are slow levels relative to clk_sys.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module cdsp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      meta_q <= '0;
      dout <= '0;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// ---- hdl/cdsp_fifo.sv ----
// Purpose: Small valid/ready FIFO for register write words.
// Assumes: DEPTH is a power of two.
// Notes: Full and empty come from a separate occupancy count.
`timescale 1ns/1ps
module cdsp_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // The count is one bit wider than the pointers, so that a full FIFO can show DEPTH.
  assign in_ready = (cnt_q < (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// ---- hdl/cdsp_port.sv ----
// Purpose: Serial register-access port, four-wire or two-wire variant.
// Assumes: Pins are asynchronous to clk_sys and are oversampled by it.
// Notes: The register bank sits outside; writes leave through a FIFO.
`timescale 1ns/1ps
module cdsp_port #(
  parameter bit USE_I2C = 1'b0,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Four-wire pins
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // Two-wire pins
  input wire logic i2c_scl,
  input wire logic i2c_sda_i,
  output logic i2c_sda_o,
  output logic i2c_sda_oe,
  input wire logic slave_addr_select_lsb,
  input wire logic slave_addr_select_msb,
  // Register bank
  output logic reg_wr_valid,
  input wire logic reg_wr_ready,
  output logic [cdsp_pkg::ADDR_W-1:0] reg_wr_addr,
  output logic [cdsp_pkg::DATA_W-1:0] reg_wr_data,
  output logic [cdsp_pkg::ADDR_W-1:0] reg_rd_addr,
  input wire logic [cdsp_pkg::DATA_W-1:0] reg_rd_data
);
  localparam int FW = cdsp_pkg::ADDR_W + cdsp_pkg::DATA_W;
  logic [6:0] pins_s;
  logic sclk_s, cs_s, sdi_s, scl_s, sda_s, sclk_p_q, scl_p_q, sda_p_q;
  logic [9:0] ptr_q;
  logic sat_q;
  logic ptr_load, ptr_inc, ptr_clr;
  logic [9:0] ptr_val;
  logic fifo_push, fifo_ready;
  logic [FW-1:0] fifo_in;

  cdsp_sync #(.W(7)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .din({spi_sclk, spi_cs_n, spi_sdi, i2c_scl, i2c_sda_i, slave_addr_select_msb, slave_addr_select_lsb}),
    .dout(pins_s)
  );
  assign {sclk_s, cs_s, sdi_s, scl_s, sda_s} = pins_s[6:2];

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      sclk_p_q <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      sclk_p_q <= sclk_s;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Four-wire engine.
  cdsp_pkg::cdsp_spi_e sp_state_q;
  logic [3:0] sp_cnt_q;
  logic [15:0] sp_sh_q, sp_tx_q, spi_word;
  logic spi_rise, spi_fall, spi_done, sp_push, sp_load, sp_inc;

  // Edges only count while selected, so the idle clock level never matters.
  assign spi_rise = sclk_s && !sclk_p_q && !cs_s;
  assign spi_fall = !sclk_s && sclk_p_q && !cs_s;
  assign spi_word = {sp_sh_q[14:0], sdi_s};
  assign spi_done = spi_rise && (sp_cnt_q == cdsp_pkg::SPI_LAST_BIT);
  assign sp_load = spi_done && (sp_state_q == cdsp_pkg::SP_CMD)
    && (spi_word[cdsp_pkg::CMD_EN_HI:cdsp_pkg::CMD_EN_LO] == cdsp_pkg::SPI_EN_PAT);
  assign sp_push = spi_done && (sp_state_q == cdsp_pkg::SP_WR) && !sat_q && fifo_ready;
  assign sp_inc = sp_push
    || (spi_fall && (sp_state_q == cdsp_pkg::SP_RD) && (sp_cnt_q == cdsp_pkg::BIT_ZERO));

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      sp_state_q <= cdsp_pkg::SP_CMD;
      sp_cnt_q <= cdsp_pkg::BIT_ZERO;
      sp_sh_q <= 16'h0000;
    end
    else if (cs_s)
    begin
      // A rising select drops any partial word.
      sp_state_q <= cdsp_pkg::SP_CMD;
      sp_cnt_q <= cdsp_pkg::BIT_ZERO;
    end
    else if (spi_rise)
    begin
      sp_sh_q <= spi_word;
      sp_cnt_q <= sp_cnt_q + 1'b1;
      if (spi_done && sp_state_q == cdsp_pkg::SP_CMD)
      begin
        if (!sp_load)
          sp_state_q <= cdsp_pkg::SP_SKIP;
        else if (spi_word[cdsp_pkg::CMD_DIR_BIT])
          sp_state_q <= cdsp_pkg::SP_RD;
        else
          sp_state_q <= cdsp_pkg::SP_WR;
      end
    end
  end

  // Readback changes only on falling edges and is released when deselected.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      sp_tx_q <= 16'h0000;
      spi_sdo <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end
    else
    begin
      spi_sdo_oe <= !cs_s && (sp_state_q == cdsp_pkg::SP_RD);
      if (spi_fall && sp_state_q == cdsp_pkg::SP_RD)
      begin
        if (sp_cnt_q == cdsp_pkg::BIT_ZERO)
        begin
          spi_sdo <= reg_rd_data[15];
          sp_tx_q <= {reg_rd_data[14:0], 1'b0};
        end
        else
        begin
          spi_sdo <= sp_tx_q[15];
          sp_tx_q <= {sp_tx_q[14:0], 1'b0};
        end
      end
    end
  end

  // Two-wire engine.
  cdsp_pkg::cdsp_i2c_e i2_state_q;
  logic [3:0] i2_cnt_q;
  logic [7:0] i2_sh_q, i2_tx_q, i2_hi_q;
  logic [15:0] i2_word_q;
  logic [1:0] i2_idx_q;
  logic i2_dir_q, i2_lo_q, i2_nack_q;
  logic i2_start, i2_stop, i2_rise, i2_fall, i2_match, i2_byte, i2_push, i2_load, i2_inc;

  assign i2_start = scl_s && scl_p_q && !sda_s && sda_p_q;
  assign i2_stop = scl_s && scl_p_q && sda_s && !sda_p_q;
  assign i2_rise = scl_s && !scl_p_q;
  assign i2_fall = !scl_s && scl_p_q;
  assign i2_match = (i2_sh_q[7:1] == {cdsp_pkg::I2C_ADDR_BASE, pins_s[1], pins_s[0]});
  assign i2_byte = i2_fall && (i2_cnt_q == cdsp_pkg::I2C_LAST_DATA);
  assign i2_load = i2_byte && (i2_state_q == cdsp_pkg::I2_WR) && (i2_idx_q == cdsp_pkg::IDX_PTR_LO);
  assign i2_push = i2_byte && (i2_state_q == cdsp_pkg::I2_WR) && (i2_idx_q == cdsp_pkg::IDX_DAT_LO)
    && !sat_q && fifo_ready;
  // The read pointer moves as the low byte leaves the latched word, so the next word is fetched in time.
  assign i2_inc = i2_push || (i2_fall && (i2_state_q == cdsp_pkg::I2_RD)
    && (i2_cnt_q == cdsp_pkg::I2C_ACK_SLOT) && !i2_nack_q && !i2_lo_q);
  assign i2c_sda_o = 1'b0;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      i2_state_q <= cdsp_pkg::I2_IDLE;
      i2_cnt_q <= cdsp_pkg::BIT_ZERO;
      i2_sh_q <= 8'h00;
      i2_tx_q <= 8'h00;
      i2_hi_q <= 8'h00;
      i2_word_q <= 16'h0000;
      i2_idx_q <= cdsp_pkg::IDX_PTR_HI;
      i2_dir_q <= 1'b0;
      i2_lo_q <= 1'b0;
      i2_nack_q <= 1'b0;
      i2c_sda_oe <= 1'b0;
    end
    else if (i2_stop)
    begin
      i2_state_q <= cdsp_pkg::I2_IDLE;
      i2c_sda_oe <= 1'b0;
    end
    else if (i2_start)
    begin
      i2_state_q <= cdsp_pkg::I2_DEV;
      // The start's own falling clock wraps the count from all ones to zero, so it is not taken as a bit.
      i2_cnt_q <= '1;
      i2c_sda_oe <= 1'b0;
    end
    else if (i2_state_q != cdsp_pkg::I2_IDLE)
    begin
      if (i2_rise)
      begin
        if (i2_cnt_q == cdsp_pkg::I2C_ACK_SLOT)
          i2_nack_q <= sda_s;
        else
          i2_sh_q <= {i2_sh_q[6:0], sda_s};
      end
      else if (i2_byte)
      begin
        i2_cnt_q <= cdsp_pkg::I2C_ACK_SLOT;
        if (i2_state_q == cdsp_pkg::I2_DEV)
        begin
          i2c_sda_oe <= i2_match;
          i2_dir_q <= i2_sh_q[0];
          if (!i2_match)
            i2_state_q <= cdsp_pkg::I2_IDLE;
        end
        else if (i2_state_q == cdsp_pkg::I2_WR)
        begin
          i2c_sda_oe <= 1'b1;
          i2_idx_q <= (i2_idx_q == cdsp_pkg::IDX_DAT_LO) ? cdsp_pkg::IDX_DAT_HI : i2_idx_q + 1'b1;
          if (i2_idx_q == cdsp_pkg::IDX_PTR_HI || i2_idx_q == cdsp_pkg::IDX_DAT_HI)
            i2_hi_q <= i2_sh_q;
        end
        else
          i2c_sda_oe <= 1'b0;
      end
      else if (i2_fall && i2_cnt_q == cdsp_pkg::I2C_ACK_SLOT)
      begin
        i2_cnt_q <= cdsp_pkg::BIT_ZERO;
        i2c_sda_oe <= 1'b0;
        if (i2_state_q == cdsp_pkg::I2_DEV)
        begin
          i2_state_q <= i2_dir_q ? cdsp_pkg::I2_RD : cdsp_pkg::I2_WR;
          i2_idx_q <= cdsp_pkg::IDX_PTR_HI;
          i2_nack_q <= 1'b0;
          i2_lo_q <= 1'b0;
        end
        if ((i2_state_q == cdsp_pkg::I2_DEV && i2_dir_q) || (i2_state_q == cdsp_pkg::I2_RD && !i2_nack_q))
        begin
          // High byte is latched with the word so the low byte matches it.
          if (i2_state_q == cdsp_pkg::I2_DEV || i2_lo_q)
          begin
            i2_word_q <= reg_rd_data;
            i2c_sda_oe <= !reg_rd_data[15];
            i2_tx_q <= reg_rd_data[14:7];
            i2_lo_q <= 1'b0;
          end
          else
          begin
            i2c_sda_oe <= !i2_word_q[7];
            i2_tx_q <= {i2_word_q[6:0], 1'b0};
            i2_lo_q <= 1'b1;
          end
        end
        else if (i2_state_q == cdsp_pkg::I2_RD)
          i2_state_q <= cdsp_pkg::I2_IDLE;
      end
      else if (i2_fall && i2_state_q == cdsp_pkg::I2_RD)
      begin
        i2_cnt_q <= i2_cnt_q + 1'b1;
        i2c_sda_oe <= !i2_tx_q[7];
        i2_tx_q <= {i2_tx_q[6:0], 1'b0};
      end
      else if (i2_fall)
        i2_cnt_q <= i2_cnt_q + 1'b1;
    end
  end

  // Shared pointer; a word accepted at the top address saturates it.
  assign ptr_clr = USE_I2C && i2_stop;
  assign ptr_load = USE_I2C ? i2_load : sp_load;
  assign ptr_val = USE_I2C ? {i2_hi_q[1:0], i2_sh_q} : spi_word[9:0];
  assign ptr_inc = USE_I2C ? i2_inc : sp_inc;
  assign reg_rd_addr = ptr_q;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      ptr_q <= cdsp_pkg::PTR_ZERO;
      sat_q <= 1'b0;
    end
    else if (ptr_clr)
    begin
      ptr_q <= cdsp_pkg::PTR_ZERO;
      sat_q <= 1'b0;
    end
    else if (ptr_load)
    begin
      ptr_q <= ptr_val;
      sat_q <= 1'b0;
    end
    else if (ptr_inc)
    begin
      if (ptr_q == cdsp_pkg::PTR_MAX)
        sat_q <= 1'b1;
      else
        ptr_q <= ptr_q + 1'b1;
    end
  end

  // A full FIFO drops the word rather than stalling a host-clocked link.
  assign fifo_push = USE_I2C ? i2_push : sp_push;
  assign fifo_in = USE_I2C ? {ptr_q, i2_hi_q, i2_sh_q} : {ptr_q, spi_word};

  cdsp_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(fifo_push),
    .in_ready(fifo_ready),
    .in_data(fifo_in),
    .out_valid(reg_wr_valid),
    .out_ready(reg_wr_ready),
    .out_data({reg_wr_addr, reg_wr_data})
  );

  chk_sdo_release: assert property (@(posedge clk_sys) disable iff (reset) cs_s |=> !spi_sdo_oe)
    else $error("data output driven while deselected");
  chk_bad_enable: assert property (@(posedge clk_sys) disable iff (reset)
    spi_done && sp_state_q == cdsp_pkg::SP_CMD && !sp_load && !USE_I2C |=> sp_state_q == cdsp_pkg::SP_SKIP)
    else $error("command without enable pattern accepted");
  chk_read_dir: assert property (@(posedge clk_sys) disable iff (reset)
    sp_load && spi_word[cdsp_pkg::CMD_DIR_BIT] |=> sp_state_q == cdsp_pkg::SP_RD ##1 spi_sdo_oe)
    else $error("read command did not enter read");
  chk_ptr_load: assert property (@(posedge clk_sys) disable iff (reset)
    ptr_load && !ptr_clr |=> ptr_q == $past(ptr_val) && !sat_q)
    else $error("pointer not loaded");
  chk_no_wrap: assert property (@(posedge clk_sys) disable iff (reset)
    ptr_q == cdsp_pkg::PTR_MAX && !ptr_load && !ptr_clr |=> ptr_q == cdsp_pkg::PTR_MAX)
    else $error("pointer wrapped");
  chk_write_push: assert property (@(posedge clk_sys) disable iff (reset)
    !USE_I2C && spi_done && sp_state_q == cdsp_pkg::SP_WR && !sat_q && !reg_wr_valid |=> reg_wr_valid)
    else $error("complete write word not stored");
  chk_sdo_shift: assert property (@(posedge clk_sys) disable iff (reset)
    spi_fall && sp_state_q == cdsp_pkg::SP_RD && sp_cnt_q != cdsp_pkg::BIT_ZERO |=> spi_sdo == $past(sp_tx_q[15]))
    else $error("readback bit not shifted on falling edge");
  chk_stop_clear: assert property (@(posedge clk_sys) disable iff (reset)
    USE_I2C && i2_stop |=> ptr_q == cdsp_pkg::PTR_ZERO && i2_state_q == cdsp_pkg::I2_IDLE)
    else $error("stop did not clear pointer");
  chk_addr_ack: assert property (@(posedge clk_sys) disable iff (reset)
    i2_byte && i2_state_q == cdsp_pkg::I2_DEV && i2_match && !i2_stop && !i2_start |=> i2c_sda_oe)
    else $error("own address not acknowledged");
endmodule

// ---- sim/cdsp_host_model.sv ----
// Purpose: Host master of the four-wire link, driving whole frames on request.
// Assumes: Link clock period of 200 ns; the clock stands still between frames.
// Notes: Also counts bits where the data output enable disagrees with what is expected.
`timescale 1ns/1ps
module cdsp_host_model (
  // Four-wire pins
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe
);
  localparam time HALF = 100ns;
  logic [15:0] wd [0:15];
  logic [15:0] rd [0:15];
  int oe_err;

  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
    oe_err = 0;
  end

  // Read data is taken late in the high phase, because the output trails the falling edge by several cycles.
  // The enable is checked mid-phase, before a read command's last rise has had time to turn it on.
  task automatic shift_word(input logic [15:0] w, input int nb, input bit drive, output logic [15:0] r);
    for (int i = 15; i > 15 - nb; i--)
    begin
      spi_sclk = 1'b0;
      spi_sdi = w[i];
      #HALF;
      spi_sclk = 1'b1;
      #(HALF / 2);
      if (spi_sdo_oe !== drive) oe_err++;
      #(HALF / 2);
      r[i] = spi_sdo;
    end
  endtask

  task automatic frame(input logic [15:0] cmd, input int nw, input int npart, input bit idle_hi, input bit drive);
    logic [15:0] junk;
    spi_sclk = idle_hi;
    #HALF;
    spi_cs_n = 1'b0;
    #HALF;
    shift_word(cmd, 16, 1'b0, junk);
    for (int k = 0; k < nw; k++)
      shift_word(wd[k], 16, drive, rd[k]);
    if (npart > 0)
      shift_word(16'hA5A5, npart, drive, junk);
    spi_sclk = idle_hi;
    #HALF;
    spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi;
    #HALF;
  endtask
endmodule

// ---- sim/tb_cdc_serial_register_port.sv ----
// Purpose: Self-checking bench of the four-wire variant with a behavioural register bank.
// Assumes: Two-wire pins idle high; expectations come from a shadow copy of the bank.
// Notes: The bank stalls at random, and on purpose long enough to fill the write FIFO.
`timescale 1ns/1ps
module tb_cdc_serial_register_port;
  logic clk_sys, reset, reg_wr_ready, stall;
  logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
  logic reg_wr_valid, i2c_sda_oe;
  logic [1:0] addr_sel;
  logic [9:0] reg_wr_addr, reg_rd_addr;
  logic [15:0] reg_wr_data, reg_rd_data;
  logic [15:0] bank [0:1023];
  logic [15:0] shadow [0:1023];
  logic [25:0] expq [$];
  logic [31:0] seed, rseed, r;
  int error_cnt, samples_checked, cyc;

  cdsp_port #(.USE_I2C(1'b0), .FIFO_DEPTH(4)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .i2c_scl(1'b1), .i2c_sda_i(1'b1), .i2c_sda_o(),
    .i2c_sda_oe(i2c_sda_oe), .slave_addr_select_lsb(addr_sel[0]), .slave_addr_select_msb(addr_sel[1]),
    .reg_wr_valid(reg_wr_valid), .reg_wr_ready(reg_wr_ready), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data));

  cdsp_host_model host_u (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function automatic logic [15:0] cmd(input logic rd, input logic [9:0] a);
    return {cdsp_pkg::SPI_EN_PAT, rd, a};
  endfunction

  task automatic close_out();
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp_word(input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %0t word expected %h got %h", $time, e, g);
    end
  endtask

  task automatic cmp_wr(input logic [25:0] e, input logic [25:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %0t bank write expected %h got %h", $time, e, g);
    end
  endtask

  task automatic cmp_cnt(input int e, input int g);
    samples_checked++;
    if (g != e)
    begin
      error_cnt++;
      $display("MISMATCH %0t count expected %0d got %0d", $time, e, g);
    end
  endtask

  // Words past the top address are not expected at all: a write there would surface as unexpected.
  task automatic wr_frame(input logic [9:0] a, input int nw, input int npart, input bit idle_hi, input int keep);
    int p;
    for (int k = 0; k < nw; k++)
    begin
      seed = xs(seed);
      host_u.wd[k] = seed[15:0];
      p = a + k;
      if (p <= 1023 && k < keep)
      begin
        expq.push_back({p[9:0], seed[15:0]});
        shadow[p] = seed[15:0];
      end
    end
    host_u.frame(cmd(1'b0, a), nw, npart, idle_hi, 1'b0);
  endtask

  task automatic rd_frame(input logic [9:0] a, input int nw, input bit idle_hi);
    int p;
    host_u.frame(cmd(1'b1, a), nw, 0, idle_hi, 1'b1);
    for (int k = 0; k < nw; k++)
    begin
      p = (a + k > 1023) ? 1023 : a + k;
      cmp_word(shadow[p], host_u.rd[k]);
    end
  endtask

  task automatic settle();
    for (int i = 0; i < 300 && expq.size() != 0; i++)
      @(posedge clk_sys);
    repeat (8) @(posedge clk_sys);
    #2;
    cmp_cnt(0, expq.size());
    cmp_word(16'h0000, {15'h0000, spi_sdo_oe});
    cmp_word(16'h0000, {15'h0000, i2c_sda_oe});
  endtask

  assign reg_rd_data = bank[reg_rd_addr];

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (!reset && reg_wr_valid === 1'b1 && reg_wr_ready)
    begin
      if (expq.size() == 0)
        cmp_cnt(0, 1);
      else
        cmp_wr(expq.pop_front(), {reg_wr_addr, reg_wr_data});
      bank[reg_wr_addr] <= reg_wr_data;
    end
    if (cyc == 30000)
    begin
      error_cnt++;
      close_out();
    end
    #2;
    rseed = xs(rseed);
    reg_wr_ready <= !stall && rseed[1:0] != 2'h0;
  end

  initial
  begin
    reset = 1'b1;
    stall = 1'b0;
    addr_sel = 2'h0;
    reg_wr_ready = 1'b0;
    seed = 32'h38;
    rseed = 32'h38;
    error_cnt = 0;
    samples_checked = 0;
    cyc = 0;
    for (int i = 0; i < 1024; i++)
    begin
      bank[i] = 16'hC3C3 ^ i[15:0];
      shadow[i] = 16'hC3C3 ^ i[15:0];
    end
    repeat (8) @(posedge clk_sys);
    #2;
    reset = 1'b0;
    repeat (6) @(posedge clk_sys);
    #2;
    for (int n = 0; n < 6; n++)
    begin
      seed = xs(seed);
      r = seed;
      addr_sel = r[14:13];
      wr_frame(r[9:0], 1 + r[11:10], 0, r[12], 16);
      settle();
      rd_frame(r[9:0], 2 + r[11:10], ~r[12]);
      settle();
    end
    wr_frame(10'h3FE, 3, 0, 1'b0, 16);
    settle();
    rd_frame(10'h3FE, 4, 1'b1);
    settle();
    wr_frame(10'h040, 1, 7, 1'b1, 16);
    settle();
    host_u.frame({5'h1D, 1'b0, 10'h041}, 1, 0, 1'b0, 1'b0);
    settle();
    host_u.frame({5'h0C, 1'b1, 10'h040}, 2, 0, 1'b0, 1'b0);
    settle();
    rd_frame(10'h040, 3, 1'b0);
    settle();
    // Holding the bank off over six words fills the four-word FIFO; the rest must be dropped.
    stall = 1'b1;
    wr_frame(10'h100, 6, 0, 1'b0, 4);
    stall = 1'b0;
    settle();
    rd_frame(10'h100, 6, 1'b1);
    settle();
    cmp_cnt(0, host_u.oe_err);
    close_out();
  end
endmodule
